// *** design/tmt_pkg.sv ***
// constants shared by the triple match timer
package tmt_pkg;
  localparam int          TMT_NUM_TIMERS = 3;               // independent sub-timers
  localparam int          TMT_CNT_W      = 32;              // counter width
  localparam logic [31:0] TMT_CNT_RST    = 32'h0000_0000;   // counter after reset
  localparam logic [31:0] TMT_MATCH_RST  = 32'hFFFF_FFFF;   // match value after reset
  localparam int          TMT_ST_MATCH1  = 0;               // status bit: match 1
  localparam int          TMT_ST_MATCH2  = 1;               // status bit: match 2
  localparam int          TMT_ST_OVF     = 2;               // status bit: overflow
  localparam int          TMT_ST_W       = 3;               // status bits per timer
endpackage : tmt_pkg

// *** design/tmt_timer.sv ***
// three independent up/down match timers with sticky status and one interrupt
// How it works
// R1: three independent sub-timers, 32-bit counters each
// R2: count each clock, direction set by software
// R3: two software match values per sub-timer
// R4: match raises interrupt in same cycle; here the interrupt rises one edge after the match is seen
// R5: overflow interrupts only when software allows it
// R6: enable bit, sticky status, write-one clears
//
// notes for the next engineer
//   - compare uses the counter value before the edge, so a
//     match is flagged and the interrupt rises one edge later
//   - a disabled timer neither counts nor compares
//   - load beats counting; a wrap in the load cycle is no wrap
//   - overflow is all ones to zero up, zero to all ones down
//   - the overflow flag is barred while its allow bit is low
//   - flags are sticky; a set in the clear cycle wins
//   - the interrupt is the registered or of every flag
//   - match values leave reset as all ones, so an up count
//     from zero first matches just before it wraps
//   - no software registers here; a bus wrapper outside
//     turns its writes into the strobes below
`timescale 1ns/1ps
`default_nettype none
module tmt_timer #(
  parameter int N = tmt_pkg::TMT_NUM_TIMERS,
  parameter int W = tmt_pkg::TMT_CNT_W
) (
  input  wire logic                       i_clk,        // system oscillator clock
  input  wire logic                       i_rst_b,      // sync reset, active low
  input  wire logic [N-1:0]               i_enable,     // per-timer run enable
  input  wire logic [N-1:0]               i_count_down, // 1 down, 0 up
  input  wire logic [N-1:0]               i_ovf_int_en, // overflow interrupt allow
  input  wire logic [N-1:0]               i_load,       // load pulse per timer
  input  wire logic [N*W-1:0]             i_load_val,   // load values
  input  wire logic [N-1:0]               i_match_wr,   // match write strobe
  input  wire logic [N*2*W-1:0]           i_match_val,  // {match2,match1} per timer
  input  wire logic [N*tmt_pkg::TMT_ST_W-1:0] i_status_clr, // write one to clear
  output logic      [N*W-1:0]             o_count,      // live counters
  output logic      [N*tmt_pkg::TMT_ST_W-1:0] o_status, // sticky flags
  output logic                            o_irq         // timer interrupt, high
);
  localparam int SW = tmt_pkg::TMT_ST_W;

  // whole state of the block
  // one packed struct keeps every flop in a single register
  // process, so reset and update cannot drift apart
  // counters, match values, flags and the interrupt live here
  typedef struct packed {
    logic [N-1:0][W-1:0]    cnt;    // counters
    logic [N-1:0][W-1:0]    m1;     // first match value
    logic [N-1:0][W-1:0]    m2;     // second match value
    logic [N-1:0][SW-1:0]   st;     // sticky status
    logic                   irq;    // registered interrupt
  } tmt_state_t;

  tmt_state_t s;       // current state
  tmt_state_t next_s;  // next state

  logic [N-1:0] hit1;  // count equals match 1
  logic [N-1:0] hit2;  // count equals match 2
  logic [N-1:0] ovf;   // wrap this cycle

  // per-timer compare and wrap detection
  // compares look at the current counter, not the next one
  // enable gates the compare so a parked timer stays silent
  // a load pulse masks the wrap: the loaded value replaces
  // the counter, so no wrap really happens in that cycle
  // the same gating keeps a parked counter from flagging
  for (genvar g = 0; g < N; g++) begin : g_cmp
    assign hit1[g] = i_enable[g] && (s.cnt[g] == s.m1[g]);            // [R3] [R4]
    assign hit2[g] = i_enable[g] && (s.cnt[g] == s.m2[g]);            // [R3] [R4]
    assign ovf[g]  = i_enable[g] && !i_load[g] &&
                     (i_count_down[g] ? (s.cnt[g] == '0) : (s.cnt[g] == '1));
  end

  // next-state logic
  // starts from the held state so every field has a value
  // on every path; matches change on a write, counters on load or enable, flags and irq are recomputed each cycle
  // order inside each timer:
  //   match write, then counter, then flags
  // flags take the hits of this cycle so a match seen now
  // shows in the status and interrupt after the next edge
  always_comb begin
    next_s = s;
    for (int i = 0; i < N; i++) begin
      // match registers written by software
      if (i_match_wr[i]) begin
        next_s.m1[i] = i_match_val[i*2*W +: W];                       // [R3]
        next_s.m2[i] = i_match_val[i*2*W+W +: W];                     // [R3]
      end
      // counter: load wins, else count when enabled
      if (i_load[i]) begin
        next_s.cnt[i] = i_load_val[i*W +: W];
      end else if (i_enable[i]) begin
        if (i_count_down[i]) begin
          next_s.cnt[i] = s.cnt[i] - 1'b1;                            // [R1] [R2]
        end else begin
          next_s.cnt[i] = s.cnt[i] + 1'b1;                            // [R1] [R2]
        end
      end
      // sticky flags, set beats clear
      next_s.st[i] = (s.st[i] & ~i_status_clr[i*SW +: SW]) |
                     {ovf[i] & i_ovf_int_en[i], hit2[i], hit1[i]};    // [R5] [R6]
    end
    // interrupt from set flags or a match seen this cycle
    next_s.irq = (|next_s.st);                                        // [R4] [R6]
  end

  // state register
  // synchronous active-low reset puts constants only
  // counters go to zero, matches to all ones
  // flags and the interrupt start clear
  // otherwise the whole struct follows its next value
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < N; i++) begin
        s.cnt[i] <= tmt_pkg::TMT_CNT_RST;
        s.m1[i]  <= tmt_pkg::TMT_MATCH_RST;
        s.m2[i]  <= tmt_pkg::TMT_MATCH_RST;
      end
      s.st  <= '0;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  // plain wiring of register fields, no logic in the path
  // counters show the live value of every sub-timer
  // status keeps the per-timer layout of the clear strobe
  always_comb begin
    o_count  = s.cnt;
    o_status = s.st;
    o_irq    = s.irq;
  end

  // checks
  // all properties sample on the rising edge and stay off
  // while reset is held low
  // single-timer checks first, then one copy per timer

  a_match_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    hit1[0] |=> s.st[0][tmt_pkg::TMT_ST_MATCH1]) else $error("match1 flag missed"); // [R4]
  a_match2_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    hit2[1] |=> s.st[1][tmt_pkg::TMT_ST_MATCH2]) else $error("match2 flag missed"); // [R4]
  a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (hit1[2] || hit2[2]) |=> o_irq) else $error("irq not raised on match"); // [R4]
  a_ovf_masked: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ovf[0] && !i_ovf_int_en[0] && !s.st[0][tmt_pkg::TMT_ST_OVF])
    |=> !s.st[0][tmt_pkg::TMT_ST_OVF]) else $error("masked overflow flagged"); // [R5]
  a_ovf_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (ovf[1] && i_ovf_int_en[1]) |=> s.st[1][tmt_pkg::TMT_ST_OVF])
    else $error("overflow flag missed"); // [R5]
  a_count_up: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_enable[0] && !i_count_down[0] && !i_load[0]) |=> s.cnt[0] == $past(s.cnt[0]) + 1'b1)
    else $error("up count wrong"); // [R2]
  a_count_down: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_enable[2] && i_count_down[2] && !i_load[2]) |=> s.cnt[2] == $past(s.cnt[2]) - 1'b1)
    else $error("down count wrong"); // [R2]
  a_hold_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!i_enable[1] && !i_load[1]) |=> $stable(s.cnt[1])) else $error("idle timer moved"); // [R1]
  a_sticky_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s.st[0][0] && !i_status_clr[0]) |=> s.st[0][0]) else $error("flag lost"); // [R6]
  a_irq_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (s.st == '0) |-> !o_irq) else $error("spurious irq"); // [R6]

  // interrupt always equals the or of the flags
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
    o_irq == (|s.st))
    else $error("irq differs from flags");

  // per-timer checks, one copy for each sub-timer
  // indices are constant inside each copy
  for (genvar g = 0; g < N; g++) begin : g_chk
    // a load pulse puts its value in the counter
    a_load_takes: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R1]
      i_load[g] |=> s.cnt[g] == $past(i_load_val[g*W +: W]))
      else $error("load value lost");

    // a match write stores the first value
    a_match_store: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R3]
      i_match_wr[g] |=> s.m1[g] == $past(i_match_val[g*2*W +: W]))
      else $error("match value lost");

    // first match sets its sticky flag
    a_hit1_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
      hit1[g] |=> s.st[g][tmt_pkg::TMT_ST_MATCH1])
      else $error("match1 flag not set");

    // second match sets its sticky flag
    a_hit2_sets: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
      hit2[g] |=> s.st[g][tmt_pkg::TMT_ST_MATCH2])
      else $error("match2 flag not set");

    // allowed wrap sets the overflow flag
    a_ovf_allowed: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R5]
      (ovf[g] && i_ovf_int_en[g]) |=> s.st[g][tmt_pkg::TMT_ST_OVF])
      else $error("allowed overflow missed");

    // no allowed wrap leaves a clear overflow flag clear
    a_ovf_barred: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R5]
      (!(ovf[g] && i_ovf_int_en[g]) && !s.st[g][tmt_pkg::TMT_ST_OVF])
      |=> !s.st[g][tmt_pkg::TMT_ST_OVF])
      else $error("overflow flag without cause");

    // parked timer holds its count
    a_parked_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
      (!i_enable[g] && !i_load[g]) |=> $stable(s.cnt[g]))
      else $error("parked timer moved");
  end

  // main scenarios reached
  c_match: cover property (@(posedge i_clk) disable iff (!i_rst_b) hit1[0] ##1 o_irq);
  c_ovf: cover property (@(posedge i_clk) disable iff (!i_rst_b) ovf[0] && i_ovf_int_en[0]);
  c_clear: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    s.st[0][0] ##1 i_status_clr[0] ##1 !s.st[0][0]);
  c_down_match: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    hit1[2] && i_count_down[2]);
  c_match2: cover property (@(posedge i_clk) disable iff (!i_rst_b) hit2[1] ##1 o_irq);
endmodule : tmt_timer
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the triple match timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         i_clk = 1'b0;
  logic         i_rst_b = 1'b0;
  logic [2:0]   i_enable = '0, i_count_down = '0, i_ovf_int_en = '0, i_load = '0, i_match_wr = '0;
  logic [95:0]  i_load_val = '0;
  logic [191:0] i_match_val = '0;
  logic [8:0]   i_status_clr = '0;
  logic [95:0]  o_count;
  logic [8:0]   o_status;
  logic         o_irq;
  int           errors = 0, comparisons = 0, cycles = 0;
  tmt_timer tmt_timer_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_enable(i_enable),
    .i_count_down(i_count_down), .i_ovf_int_en(i_ovf_int_en), .i_load(i_load),
    .i_load_val(i_load_val), .i_match_wr(i_match_wr), .i_match_val(i_match_val),
    .i_status_clr(i_status_clr), .o_count(o_count), .o_status(o_status), .o_irq(o_irq));
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 2000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask : step
  task automatic final_report();
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // timer 0 counts up through both match values, then is cleared and halted
  task automatic match_up();
    i_load = 3'h1; i_load_val[31:0] = 32'h5; i_match_wr = 3'h1; i_match_val[63:0] = {32'h9, 32'h7};
    step(1);
    i_load = '0; i_match_wr = '0; i_enable = 3'h1;
    step(3);
    chk(o_count[31:0], 32'h8);
    chk({o_irq, o_status}, 32'h201);
    step(2);
    chk(o_status, 32'h3);
    i_enable = '0; i_status_clr = 9'h003;
    step(1);
    i_status_clr = '0;
    chk({o_irq, o_status}, 32'h0);
    step(2);
    chk(o_count[31:0], 32'hA);
    chk(o_count[95:64], 32'h0);
  endtask : match_up
  // timer 1 wraps downward, first with overflow flag barred, then allowed
  task automatic ovf_down();
    i_load = 3'h2; i_count_down = 3'h2;
    step(1);
    i_load = '0; i_enable = 3'h2;
    step(1);
    i_enable = '0; i_load = 3'h2;
    chk(o_count[63:32], 32'hFFFF_FFFF);
    chk(o_status, 32'h0);
    step(1);
    i_load = '0; i_ovf_int_en = 3'h2; i_enable = 3'h2;
    step(1);
    i_enable = '0;
    chk({o_irq, o_status}, 32'h220);
  endtask : ovf_down
  // timer 1 up hits match 2, timer 2 down hits both matches
  task automatic match_pair();
    i_status_clr = 9'h020; i_count_down = 3'h4; i_ovf_int_en = '0;
    i_load = 3'h6; i_load_val[63:32] = 32'h10; i_load_val[95:64] = 32'h20;
    i_match_wr = 3'h6; i_match_val[127:64] = {32'h12, 32'h40};
    i_match_val[191:128] = {32'h1C, 32'h1E};
    step(1);
    i_status_clr = '0; i_load = '0; i_match_wr = '0; i_enable = 3'h6;
    chk({o_irq, o_status}, 32'h0);
    step(3);
    chk(o_count[63:32], 32'h13);
    chk(o_count[95:64], 32'h1D);
    chk({o_irq, o_status}, 32'h250);
    step(2);
    i_enable = '0;
    chk({o_irq, o_status}, 32'h2D0);
  endtask : match_pair
  // reset in mid-run, timer 0 counts from the first edge after
  task automatic reset_mid();
    i_rst_b = 1'b0; i_enable = 3'h1;
    step(2);
    i_rst_b = 1'b1;
    chk(o_count[31:0] | o_count[63:32] | o_count[95:64], 32'h0);
    chk({o_irq, o_status}, 32'h0);
    step(2);
    i_enable = '0;
    chk(o_count[31:0], 32'h2);
    chk(o_count[63:32], 32'h0);
  endtask : reset_mid
  initial begin
    step(8);
    i_rst_b = 1'b1;
    chk(o_count[31:0] | o_count[63:32] | o_count[95:64], 32'h0);
    chk({o_irq, o_status}, 32'h0);
    match_up();
    ovf_down();
    match_pair();
    reset_mid();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
